// ==== pfd_cfg.svh ====
// Purpose: Offsets, field positions, reset values of the PLL status and fine delay bank
// Assumes: 8-bit register data, 10-bit register address
// Notes:   Included by bare name; definitions only
`ifndef PFD_CFG_SVH
`define PFD_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PFD_ADDR_W            10
`define PFD_OFS_THR_CFG       10'h01a
`define PFD_OFS_PLL_STATUS    10'h01f
`define PFD_OFS_DLY_BYPASS    10'h0a0
`define PFD_OFS_DLY_CAPS      10'h0a1
`define PFD_OFS_IRQ_STATUS    10'h0f0
`define PFD_OFS_IRQ_MASK      10'h0f1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFD_BIT_THR_SEL       6
`define PFD_BIT_LOCK          0
`define PFD_BIT_FIRST_REFERENCE_INPUT_THR      1
`define PFD_BIT_SECOND_REFERENCE_INPUT_THR      2
`define PFD_BIT_OSC_THR       3
`define PFD_BIT_SECOND_REFERENCE_INPUT_SEL      4
`define PFD_BIT_HOLDOVER      5
`define PFD_BIT_CAL_DONE      6
`define PFD_BIT_BYPASS        0
`define PFD_CAPS_HI           5
`define PFD_CAPS_LO           3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PFD_RST_THR_SEL       1'h0
`define PFD_RST_BYPASS        1'h1
`define PFD_RST_CAPS          3'h0
`define PFD_RST_CAP_COUNT     3'h4
`define PFD_RST_IRQ_MASK      8'h00
`define PFD_STATUS_W          8

`endif

// ==== pfd_pkg.sv ====
// Purpose: Types of the PLL status and fine delay bank
// Assumes: pfd_cfg.svh holds every number
// Notes:   One packed struct carries all state of the main module except the event flags, which pfd_evt holds
`include "pfd_cfg.svh"

package pfd_pkg;

    // ----------------------------------------------------------------
    // Register data
    // ----------------------------------------------------------------
    typedef logic [7:0] pfd_byte_t;

    // ----------------------------------------------------------------
    // Main module state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic      thr_sel;
        logic      bypass;
        logic [2:0] caps;
        logic [2:0] cap_count;
        pfd_byte_t irq_mask;
        pfd_byte_t rd_data;
        logic      irq;
    } pfd_state_t;

endpackage

// ==== pfd_evt.sv ====
// Purpose: Change detector with sticky flags, one per monitor level
// Assumes: Levels synchronous to the clock
// Notes:   First cycle after reset only captures, so reset values raise no event
module pfd_evt #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic             clr_in,
    output logic      [WIDTH-1:0] sticky_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic             armed;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] sticky;
    } pfd_evt_state_t;

    pfd_evt_state_t st_r;
    pfd_evt_state_t st_nxt;
    logic [WIDTH-1:0] change;

    always_comb begin
        st_nxt       = st_r;
        change       = st_r.armed ? (level_in ^ st_r.prev) : '0;
        st_nxt.armed = 1'b1;
        st_nxt.prev  = level_in;
        // Set beats a clear in the same cycle, so no change is lost
        st_nxt.sticky = change | (st_r.sticky & ~{WIDTH{clr_in}});
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sticky_out = st_r.sticky;

endmodule

// ==== pfd_regs.sv ====
// Purpose: PLL monitor status and first fine delay output configuration registers
// Assumes: Monitor levels synchronous to ref_clk_in; plain strobe register port
// Notes:   Read data stand one cycle after the read strobe, zero elsewhere
//
// Behaviour
// - Oscillator threshold bit reads 1 above monitor threshold, 0 below.
// - Status bit 2 shows second reference input above threshold; read-only.
// - Status bit 1 shows first reference input above threshold; read-only.
// - Threshold for both reference monitors chosen by bit 6 at 0x01A.
// - Status bit 0 shows digital lock detect, 1 when locked; read-only.
// - Bit 0 at 0x0A0 bypasses or uses first output fine delay.
// - Bits 5..3 at 0x0A1 set ramp capacitor count for full scale.
// - Capacitor code 000 gives four (default), 001 three, 011 two, 100 three.
// - Monitor and lock flags share status at 0x01F; bit 6 calibration done.
`include "pfd_cfg.svh"

module pfd_regs
    import pfd_pkg::*;
#(
    parameter int ADDR_W = `PFD_ADDR_W
) (
    input  wire logic              ref_clk_in,
    input  wire logic              resetn_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output logic      [7:0]        rd_data_out,
    // Monitor levels from the analog core
    input  wire logic              pll_locked_in,
    input  wire logic              first_reference_input_above_in,
    input  wire logic              second_reference_input_above_in,
    input  wire logic              osc_above_in,
    input  wire logic              second_reference_input_selected_in,
    input  wire logic              holdover_active_in,
    input  wire logic              osc_cal_done_in,
    // Controls to the analog core
    output logic                   ref_thr_sel_out,
    output logic                   first_fine_delay_output_bypass_out,
    output logic      [2:0]        first_fine_delay_output_caps_out,
    output logic      [2:0]        first_fine_delay_output_cap_count_out,
    // Interrupt
    output logic                   irq_out
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic hit_thr;
    logic hit_status;
    logic hit_bypass;
    logic hit_caps;
    logic hit_irq_stat;
    logic hit_irq_mask;

    assign hit_thr      = (addr_in == ADDR_W'(`PFD_OFS_THR_CFG));
    assign hit_status   = (addr_in == ADDR_W'(`PFD_OFS_PLL_STATUS));
    assign hit_bypass   = (addr_in == ADDR_W'(`PFD_OFS_DLY_BYPASS));
    assign hit_caps     = (addr_in == ADDR_W'(`PFD_OFS_DLY_CAPS));
    assign hit_irq_stat = (addr_in == ADDR_W'(`PFD_OFS_IRQ_STATUS));
    assign hit_irq_mask = (addr_in == ADDR_W'(`PFD_OFS_IRQ_MASK));

    // ----------------------------------------------------------------
    // Live status word
    // ----------------------------------------------------------------
    // Monitors are read as they stand, no snapshot kept
    pfd_byte_t status_word;

    always_comb begin
        status_word                        = 8'h00;
        status_word[`PFD_BIT_LOCK]         = pll_locked_in;
        status_word[`PFD_BIT_FIRST_REFERENCE_INPUT_THR]     = first_reference_input_above_in;
        status_word[`PFD_BIT_SECOND_REFERENCE_INPUT_THR]     = second_reference_input_above_in;
        status_word[`PFD_BIT_OSC_THR]      = osc_above_in;
        status_word[`PFD_BIT_SECOND_REFERENCE_INPUT_SEL]     = second_reference_input_selected_in;
        status_word[`PFD_BIT_HOLDOVER]     = holdover_active_in;
        status_word[`PFD_BIT_CAL_DONE]     = osc_cal_done_in;
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    // Any change of a status bit raises the flag of the same position
    pfd_byte_t irq_sticky;
    logic      irq_clr;

    assign irq_clr = rd_en_in & hit_irq_stat;

    pfd_evt #(
        .WIDTH      (`PFD_STATUS_W)
    ) u_evt (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .level_in   (status_word),
        .clr_in     (irq_clr),
        .sticky_out (irq_sticky)
    );

    // ----------------------------------------------------------------
    // Capacitor count decode
    // ----------------------------------------------------------------
    // Each cleared bit adds one capacitor to the single fixed one
    function automatic logic [2:0] cap_count_of(input logic [2:0] code);
        logic [2:0] n;
        n = 3'h1;
        for (int i = 0; i < 3; i++) begin
            n = n + {2'h0, ~code[i]};
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pfd_state_t st_r;
    pfd_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;

        // Writes; the status word has no write path at all
        if (wr_en_in) begin
            if (hit_thr) begin
                st_nxt.thr_sel = wr_data_in[`PFD_BIT_THR_SEL];
            end
            if (hit_bypass) begin
                st_nxt.bypass = wr_data_in[`PFD_BIT_BYPASS];
            end
            if (hit_caps) begin
                st_nxt.caps = wr_data_in[`PFD_CAPS_HI:`PFD_CAPS_LO];
            end
            if (hit_irq_mask) begin
                st_nxt.irq_mask = wr_data_in;
            end
        end

        // Registered decode keeps the output glitch free
        st_nxt.cap_count = cap_count_of(st_nxt.caps);

        // Read data only in the cycle after the strobe
        st_nxt.rd_data = 8'h00;
        if (rd_en_in) begin
            if (hit_thr) begin
                st_nxt.rd_data[`PFD_BIT_THR_SEL] = st_r.thr_sel;
            end else if (hit_status) begin
                st_nxt.rd_data = status_word;
            end else if (hit_bypass) begin
                st_nxt.rd_data[`PFD_BIT_BYPASS] = st_r.bypass;
            end else if (hit_caps) begin
                st_nxt.rd_data[`PFD_CAPS_HI:`PFD_CAPS_LO] = st_r.caps;
            end else if (hit_irq_stat) begin
                st_nxt.rd_data = irq_sticky;
            end else if (hit_irq_mask) begin
                st_nxt.rd_data = st_r.irq_mask;
            end
        end

        // One cycle behind the flags, traded for a flopped output
        st_nxt.irq = |(irq_sticky & st_nxt.irq_mask);
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r.thr_sel   <= `PFD_RST_THR_SEL;
            st_r.bypass    <= `PFD_RST_BYPASS;
            st_r.caps      <= `PFD_RST_CAPS;
            st_r.cap_count <= `PFD_RST_CAP_COUNT;
            st_r.irq_mask  <= `PFD_RST_IRQ_MASK;
            st_r.rd_data   <= 8'h00;
            st_r.irq       <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data_out                           = st_r.rd_data;
    assign ref_thr_sel_out                       = st_r.thr_sel;
    assign first_fine_delay_output_bypass_out    = st_r.bypass;
    assign first_fine_delay_output_caps_out      = st_r.caps;
    assign first_fine_delay_output_cap_count_out = st_r.cap_count;
    assign irq_out                               = st_r.irq;

endmodule

// ==== pfd_chk_assertions.sv ====
// Purpose: Port assertions of the PLL status and fine delay bank
// Assumes: One clock, async active low reset
// Notes:   Bound to pfd_regs after the module
`include "pfd_cfg.svh"
module pfd_chk #(
    parameter int ADDR_W = 10
) (
    input wire logic              ref_clk_in,
    input wire logic              resetn_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0]        wr_data_in,
    input wire logic              wr_en_in,
    input wire logic              rd_en_in,
    input wire logic [7:0]        rd_data_out,
    input wire logic              pll_locked_in,
    input wire logic              first_reference_input_above_in,
    input wire logic              second_reference_input_above_in,
    input wire logic              osc_above_in,
    input wire logic              second_reference_input_selected_in,
    input wire logic              holdover_active_in,
    input wire logic              osc_cal_done_in,
    input wire logic              ref_thr_sel_out,
    input wire logic              first_fine_delay_output_bypass_out,
    input wire logic [2:0]        first_fine_delay_output_caps_out,
    input wire logic [2:0]        first_fine_delay_output_cap_count_out,
    input wire logic              irq_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);
    logic [6:0] mon_lvls;
    assign mon_lvls = {osc_cal_done_in, holdover_active_in, second_reference_input_selected_in,
        osc_above_in, second_reference_input_above_in, first_reference_input_above_in,
        pll_locked_in};
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    chk_status_live: assert property (rd_en_in && addr_in == `PFD_OFS_PLL_STATUS |=>
        rd_data_out == {1'b0, $past(osc_cal_done_in), $past(holdover_active_in),
        $past(second_reference_input_selected_in), $past(osc_above_in),
        $past(second_reference_input_above_in), $past(first_reference_input_above_in),
        $past(pll_locked_in)}) else $error("status read wrong");
    chk_thr_write: assert property (wr_en_in && addr_in == `PFD_OFS_THR_CFG |=>
        ref_thr_sel_out == $past(wr_data_in[6])) else $error("threshold select wrong");
    chk_thr_readback: assert property (rd_en_in && addr_in == `PFD_OFS_THR_CFG |=>
        rd_data_out == {1'b0, $past(ref_thr_sel_out), 6'h00}) else $error("threshold read");
    chk_bypass_write: assert property (wr_en_in && addr_in == `PFD_OFS_DLY_BYPASS |=>
        first_fine_delay_output_bypass_out == $past(wr_data_in[0])) else $error("bypass wrong");
    chk_bypass_hold: assert property (!(wr_en_in && addr_in == `PFD_OFS_DLY_BYPASS) |=>
        $stable(first_fine_delay_output_bypass_out)) else $error("bypass changed");
    chk_caps_write: assert property (wr_en_in && addr_in == `PFD_OFS_DLY_CAPS |=>
        first_fine_delay_output_caps_out == $past(wr_data_in[5:3])) else $error("caps wrong");
    chk_caps_readback: assert property (rd_en_in && addr_in == `PFD_OFS_DLY_CAPS |=>
        rd_data_out == {2'b00, $past(first_fine_delay_output_caps_out), 3'h0})
        else $error("caps read wrong");
    // Count is one plus the number of zero bits in the code
    chk_cap_decode: assert property (first_fine_delay_output_cap_count_out == 3'h4
        - {2'b00, first_fine_delay_output_caps_out[0]} - {2'b00, first_fine_delay_output_caps_out[1]}
        - {2'b00, first_fine_delay_output_caps_out[2]}) else $error("cap count wrong");
    // Clearing read with quiet monitors leaves no flag to hold the line up
    chk_irq_clear: assert property ((rd_en_in && addr_in == `PFD_OFS_IRQ_STATUS
        && $stable(mon_lvls)) ##1 $stable(mon_lvls) |=> !irq_out) else $error("irq not cleared");
endmodule
bind pfd_regs pfd_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .pll_locked_in(pll_locked_in),
    .first_reference_input_above_in(first_reference_input_above_in),
    .second_reference_input_above_in(second_reference_input_above_in),
    .osc_above_in(osc_above_in), .second_reference_input_selected_in(second_reference_input_selected_in),
    .holdover_active_in(holdover_active_in), .osc_cal_done_in(osc_cal_done_in),
    .ref_thr_sel_out(ref_thr_sel_out),
    .first_fine_delay_output_bypass_out(first_fine_delay_output_bypass_out),
    .first_fine_delay_output_caps_out(first_fine_delay_output_caps_out),
    .first_fine_delay_output_cap_count_out(first_fine_delay_output_cap_count_out),
    .irq_out(irq_out));

// ==== tb_top.sv ====
// Purpose: Register level test of the PLL status and fine delay bank
// Assumes: Plain strobe port, read data one cycle after the strobe
// Notes:   Monitor levels are driven as one vector, bit n to status bit n
`include "pfd_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk_in = 1'b0;
    logic       resetn_in  = 1'b0;
    logic       wr_en      = 1'b0;
    logic       rd_en      = 1'b0;
    logic [9:0] addr       = 10'h000;
    logic [7:0] wdata      = 8'h00;
    logic [6:0] mon        = 7'h00;
    logic [7:0] rdata;
    logic       thr, byp, irq;
    logic [2:0] caps, cnt;
    int         num_errors  = 0;
    int         check_count = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    pfd_regs uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
        .pll_locked_in(mon[0]), .first_reference_input_above_in(mon[1]),
        .second_reference_input_above_in(mon[2]), .osc_above_in(mon[3]),
        .second_reference_input_selected_in(mon[4]), .holdover_active_in(mon[5]),
        .osc_cal_done_in(mon[6]), .ref_thr_sel_out(thr),
        .first_fine_delay_output_bypass_out(byp), .first_fine_delay_output_caps_out(caps),
        .first_fine_delay_output_cap_count_out(cnt), .irq_out(irq));
    // ----------------------------------------------------------------
    // Port tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk_in);
        wr_en <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_in);
        rd_en <= 1'b0;
        #1 cmp(rdata, exp);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        #1 cmp({7'h0, byp}, 8'h01);
        cmp({5'h0, cnt}, 8'h04);
        rd(`PFD_OFS_DLY_BYPASS, 8'h01);
        rd(`PFD_OFS_DLY_CAPS, 8'h00);
        rd(`PFD_OFS_THR_CFG, 8'h00);
        wr(10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        $display("test reset done");
        wr(`PFD_OFS_THR_CFG, 8'hff);
        #1 cmp({7'h0, thr}, 8'h01);
        rd(`PFD_OFS_THR_CFG, 8'h40);
        wr(`PFD_OFS_DLY_BYPASS, 8'hfe);
        #1 cmp({7'h0, byp}, 8'h00);
        rd(`PFD_OFS_DLY_BYPASS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(`PFD_OFS_DLY_CAPS, {2'b11, 3'(i), 3'h7});
            #1 cmp({5'h0, cnt}, 8'h04 - i[0] - i[1] - i[2]);
            rd(`PFD_OFS_DLY_CAPS, {2'b00, 3'(i), 3'h0});
        end
        $display("test config done");
        mon <= 7'h55;
        rd(`PFD_OFS_PLL_STATUS, 8'h55);
        mon <= 7'h2a;
        rd(`PFD_OFS_PLL_STATUS, 8'h2a);
        wr(`PFD_OFS_PLL_STATUS, 8'hd5);
        rd(`PFD_OFS_PLL_STATUS, 8'h2a);
        $display("test status done");
        rd(`PFD_OFS_IRQ_STATUS, 8'h7f);
        mon <= 7'h28;
        repeat (4) @(posedge ref_clk_in);
        cmp({7'h0, irq}, 8'h00);
        wr(`PFD_OFS_IRQ_MASK, 8'h01);
        mon <= 7'h29;
        for (int i = 0; i < 10 && irq !== 1'b1; i++) @(posedge ref_clk_in);
        if (irq === 1'b1) begin
            rd(`PFD_OFS_IRQ_STATUS, 8'h03);
            repeat (2) @(posedge ref_clk_in);
            cmp({7'h0, irq}, 8'h00);
        end else begin
            num_errors++;
        end
        $display("test interrupt done");
        close_out();
    end
endmodule
